// [inc/tx_irq_pkg.sv]
package tx_irq_pkg;
	// Register byte offsets
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] ENABLE_OFS = 8'h04;
	localparam logic [7:0] COMMAND_OFS = 8'h08;
	localparam logic [7:0] THRESH_OFS = 8'h0C;
	localparam logic [7:0] START_OFS = 8'h10;
	localparam logic [7:0] FLAGS_OFS = 8'h14;

	// Status and enable bit positions
	localparam int SUMMARY_BIT = 16;
	localparam int UNDERFLOW_BIT = 17;
	localparam int COMPLETE_BIT = 18;
	localparam int DEFER_BIT = 19;
	localparam int NOCARR_BIT = 20;
	localparam int ABORT_BIT = 21;
	localparam int LATECOL_BIT = 22;
	localparam int DESC_BIT = 23;
	localparam int BUSERR_BIT = 24;
	localparam int EVT_LO = 17;
	localparam int EVT_N = 8;

	// Command register fields
	localparam int FULL_DUPLEX_BIT = 0;
	localparam int SPEED_100_BIT = 1;
	localparam int NO_DEFER_BIT = 2;

	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
	localparam logic [31:0] COMMAND_RST = 32'h0000_0000;
	localparam logic [31:0] THRESH_RST = 32'h0000_0001;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// Deferral and collision limits
	localparam real DEFER_100_MS = 0.32768;
	localparam real DEFER_10_MS = 3.2768;
	localparam real CLK_MHZ = 10.0;
	localparam int DEFER_100_CYC = int'(DEFER_100_MS * 1000.0 * CLK_MHZ);
	localparam int DEFER_10_CYC = int'(DEFER_10_MS * 1000.0 * CLK_MHZ);
	localparam int DEFER_W = 16;
	localparam int ABORT_COLLISIONS = 16;
	localparam int COL_W = 5;
	localparam int SLOT_BYTES = 64;
	localparam int BYTE_W = 11;

	// Transmit path events from MII side
	typedef struct packed {
		logic frame_active;
		logic frame_start;
		logic frame_ok;
		logic fifo_underflow;
		logic collision;
		logic byte_sent;
		logic defer_pending;
		logic crs;
	} tx_path_t;

	typedef struct packed {
		logic paddr_hit;
		logic wr;
		logic rd;
	} bus_ctl_t;
endpackage : tx_irq_pkg

// [src/collision_track.sv]
`timescale 1ns/1ps
module collision_track
	import tx_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Transmit path
	input tx_irq_pkg::tx_path_t path_i,
	input wire logic half_duplex_i,
	// Events
	output logic abort_o,
	output logic late_col_o
);
	logic [COL_W-1:0] col_cnt_r;
	logic [BYTE_W-1:0] byte_cnt_r;
	logic col_half;

	assign col_half = path_i.collision && half_duplex_i;

	// Collision count survives retries, cleared by a good frame or by an abort
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			col_cnt_r <= '0;
		else if (path_i.frame_ok || abort_o)
			col_cnt_r <= '0;
		else if (col_half)
			col_cnt_r <= col_cnt_r + 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			byte_cnt_r <= '0;
		else if (path_i.frame_start)
			byte_cnt_r <= '0;
		else if (path_i.byte_sent && byte_cnt_r != BYTE_W'(SLOT_BYTES))
			byte_cnt_r <= byte_cnt_r + 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			abort_o <= 1'b0;
			late_col_o <= 1'b0;
		end
		else
		begin
			abort_o <= col_half && (col_cnt_r == COL_W'(ABORT_COLLISIONS - 1));
			late_col_o <= col_half && (byte_cnt_r == BYTE_W'(SLOT_BYTES));
		end
	end
endmodule : collision_track

// [src/defer_timer.sv]
`timescale 1ns/1ps
module defer_timer
	import tx_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic enable_i,
	input wire logic speed_100_i,
	input wire logic pending_i,
	// Result
	output logic expired_o
);
	logic [DEFER_W-1:0] cnt_r;
	logic [DEFER_W-1:0] limit;
	logic counting;

	assign limit = speed_100_i ? DEFER_W'(DEFER_100_CYC) : DEFER_W'(DEFER_10_CYC);
	assign counting = enable_i && pending_i;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_r <= '0;
		else if (!counting)
			cnt_r <= '0;
		else if (cnt_r != limit)
			cnt_r <= cnt_r + 1'b1;
	end

	// One pulse on the cycle the wait passes the limit
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			expired_o <= 1'b0;
		else
			expired_o <= counting && (cnt_r == limit - 1'b1);
	end
endmodule : defer_timer

// [src/mac_tx_interrupt_status.sv]
`timescale 1ns/1ps
module mac_tx_interrupt_status
	import tx_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Transmit path
	input tx_irq_pkg::tx_path_t tx_path_i,
	input wire logic desc_unavail_i,
	input wire logic dma_bus_error_i,
	// Outputs
	output logic retransmit_o,
	output logic dma_halted_o,
	output logic tx_irq_o
);
	logic rst_meta_r;
	logic rst_n;
	logic [31:0] status_r;
	logic [31:0] status_nxt;
	logic [31:0] enable_r;
	logic [31:0] command_r;
	logic [31:0] thresh_r;
	logic carrier_seen_r;
	logic [EVT_N-1:0] events;
	logic [EVT_N-1:0] evt_status;
	logic [EVT_N-1:0] w1c;
	logic tx_summary_irq;
	logic half_duplex;
	logic no_defer_ctl;
	logic defer_exp;
	logic abort_evt;
	logic late_evt;
	logic no_carrier_evt;
	logic access;
	logic wr_en;
	logic rd_en;
	logic hit_status;
	logic hit_enable;
	logic hit_command;
	logic hit_thresh;
	logic hit_start;
	logic hit_flags;
	logic mapped;
	logic [31:0] rd_word;

	// Two-stage reset release
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// APB decode
	assign access = psel_i && penable_i;
	assign hit_status = paddr_i == STATUS_OFS;
	assign hit_enable = paddr_i == ENABLE_OFS;
	assign hit_command = paddr_i == COMMAND_OFS;
	assign hit_thresh = paddr_i == THRESH_OFS;
	assign hit_start = paddr_i == START_OFS;
	assign hit_flags = paddr_i == FLAGS_OFS;
	assign mapped = hit_status | hit_enable | hit_command | hit_thresh | hit_start | hit_flags;
	assign wr_en = access && pwrite_i && !pready_o;
	assign rd_en = access && !pwrite_i && !pready_o;

	assign half_duplex = !command_r[FULL_DUPLEX_BIT];
	assign no_defer_ctl = command_r[NO_DEFER_BIT];

	// In half duplex, carrier must show at frame start and must not drop once seen during the frame
	assign no_carrier_evt = half_duplex && tx_path_i.frame_active && !tx_path_i.crs
		&& (tx_path_i.frame_start || carrier_seen_r);

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			carrier_seen_r <= 1'b0;
		else
			carrier_seen_r <= tx_path_i.frame_active && tx_path_i.crs;
	end

	defer_timer u_defer (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.enable_i(half_duplex && !no_defer_ctl),
		.speed_100_i(command_r[SPEED_100_BIT]),
		.pending_i(tx_path_i.defer_pending),
		.expired_o(defer_exp)
	);

	collision_track u_col (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.path_i(tx_path_i),
		.half_duplex_i(half_duplex),
		.abort_o(abort_evt),
		.late_col_o(late_evt)
	);

	// Events in status order, bits 17 up to 24
	assign events = {
		dma_bus_error_i,
		desc_unavail_i && !dma_halted_o,
		late_evt,
		abort_evt,
		no_carrier_evt,
		defer_exp,
		tx_path_i.frame_ok,
		tx_path_i.fifo_underflow
	};

	assign w1c = (wr_en && hit_status) ? pwdata_i[EVT_LO +: EVT_N] : '0;
	assign evt_status = (status_r[EVT_LO +: EVT_N] & ~w1c) | events;
	assign tx_summary_irq = |(evt_status & enable_r[EVT_LO +: EVT_N]);

	always_comb
	begin
		status_nxt = STATUS_RST;
		status_nxt[EVT_LO +: EVT_N] = evt_status;
		status_nxt[SUMMARY_BIT] = tx_summary_irq;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			status_r <= STATUS_RST;
		else
			status_r <= status_nxt;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			tx_irq_o <= 1'b0;
		else
			tx_irq_o <= tx_summary_irq && enable_r[SUMMARY_BIT];
	end

	// Writable control registers
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_r <= ENABLE_RST;
			command_r <= COMMAND_RST;
			thresh_r <= THRESH_RST;
		end
		else if (wr_en)
		begin
			if (hit_enable)
				enable_r <= pwdata_i;
			if (hit_command)
				command_r <= pwdata_i;
			// Larger threshold helps against frequent underflow
			if (hit_thresh)
				thresh_r <= pwdata_i;
		end
	end

	// DMA halt held until software demands a restart
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			dma_halted_o <= 1'b0;
		else if (desc_unavail_i)
			dma_halted_o <= 1'b1;
		else if (wr_en && hit_start)
			dma_halted_o <= 1'b0;
	end

	// Retransmit request follows the underflow by one cycle
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			retransmit_o <= 1'b0;
		else
			retransmit_o <= tx_path_i.fifo_underflow;
	end

	always_comb
	begin
		rd_word = ZERO_WORD;
		if (hit_status)
			rd_word = status_r;
		else if (hit_enable)
			rd_word = enable_r;
		else if (hit_command)
			rd_word = command_r;
		else if (hit_thresh)
			rd_word = thresh_r;
		else if (hit_flags)
			rd_word = {{30{1'b0}}, retransmit_o, dma_halted_o};
	end

	// One wait state: answer registered, ready one cycle into access
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= ZERO_WORD;
		end
		else
		begin
			pready_o <= access && !pready_o;
			pslverr_o <= access && !pready_o && !mapped;
			if (rd_en)
				prdata_o <= rd_word;
		end
	end

	a_clear_keeps_event: assert property (@(posedge clk_i) disable iff (!rst_n)
		(events[COMPLETE_BIT-EVT_LO]) |=> status_r[COMPLETE_BIT])
		else $error("event lost against clear");
	a_w1c_clears: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr_en && hit_status && pwdata_i[UNDERFLOW_BIT] && !events[0]) |=> !status_r[UNDERFLOW_BIT])
		else $error("write one did not clear");
	a_zero_write_keeps: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr_en && hit_status && !pwdata_i[DEFER_BIT] && status_r[DEFER_BIT]) |=> status_r[DEFER_BIT])
		else $error("zero write changed flag");
	a_summary_or: assert property (@(posedge clk_i) disable iff (!rst_n)
		status_r[SUMMARY_BIT] == |(status_r[EVT_LO +: EVT_N] & enable_r[EVT_LO +: EVT_N]))
		else $error("summary bit mismatch");
	a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n)
		tx_irq_o |-> (status_r[SUMMARY_BIT] && $past(enable_r[SUMMARY_BIT])))
		else $error("irq without enable");
	a_full_no_carrier: assert property (@(posedge clk_i) disable iff (!rst_n)
		(command_r[FULL_DUPLEX_BIT] && !status_r[NOCARR_BIT]) |=> !status_r[NOCARR_BIT])
		else $error("no carrier in full duplex");
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		status_r[31:BUSERR_BIT+1] == '0 && status_r[SUMMARY_BIT-1:0] == '0)
		else $error("reserved bits set");
	a_underflow_retx: assert property (@(posedge clk_i) disable iff (!rst_n)
		tx_path_i.fifo_underflow |=> (retransmit_o && status_r[UNDERFLOW_BIT]))
		else $error("underflow not handled");
	a_halt_on_desc: assert property (@(posedge clk_i) disable iff (!rst_n)
		desc_unavail_i |=> (dma_halted_o && status_r[DESC_BIT]))
		else $error("desc unavail not halted");
	a_bus_err_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
		dma_bus_error_i |=> status_r[BUSERR_BIT])
		else $error("bus error not flagged");
	a_defer_mode: assert property (@(posedge clk_i) disable iff (!rst_n)
		(defer_exp) |-> $past(half_duplex && !no_defer_ctl))
		else $error("deferral checked when disabled");
	a_carrier_start: assert property (@(posedge clk_i) disable iff (!rst_n)
		(half_duplex && tx_path_i.frame_active && tx_path_i.frame_start && !tx_path_i.crs)
		|=> status_r[NOCARR_BIT])
		else $error("no carrier missed");
endmodule : mac_tx_interrupt_status

// [tb/tb_mac_tx_interrupt_status.sv]
`timescale 1ns/1ps
module tb_mac_tx_interrupt_status;
	import tx_irq_pkg::*;
	localparam tx_path_t P_START = '{frame_start: 1'b1, default: 1'b0};
	localparam tx_path_t P_OK = '{frame_ok: 1'b1, default: 1'b0};
	localparam tx_path_t P_UF = '{fifo_underflow: 1'b1, default: 1'b0};
	localparam tx_path_t P_COL = '{collision: 1'b1, default: 1'b0};
	localparam tx_path_t P_BYTE = '{byte_sent: 1'b1, default: 1'b0};
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam int LIMIT = 30000;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	tx_path_t path;
	logic desc_un = 1'b0;
	logic bus_err = 1'b0;
	logic retx;
	logic halted;
	logic irq;
	logic [31:0] rd_v;
	logic er_v;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;

	initial
	begin
		forever #50 clk = ~clk;
	end

	mac_tx_interrupt_status i_mac_tx_interrupt_status (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .tx_path_i(path), .desc_unavail_i(desc_un),
		.dma_bus_error_i(bus_err), .retransmit_o(retx), .dma_halted_o(halted), .tx_irq_o(irq));
	tx_path_model i_tx_path_model (.clk_i(clk), .path_o(path));

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			mismatches++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk

	// Ready is looked at on the low phase, so the edge that follows is the sampling edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd_v = prdata;
		er_v = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, ZERO_WORD);
		chk(what, e, rd_v & m);
	endtask : rchk

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic t_regs;
		rchk("status rst", STATUS_OFS, ALL, STATUS_RST);
		rchk("enable rst", ENABLE_OFS, ALL, ENABLE_RST);
		rchk("command rst", COMMAND_OFS, ALL, COMMAND_RST);
		rchk("thresh rst", THRESH_OFS, ALL, THRESH_RST);
		apb(1'b0, 8'h20, ZERO_WORD);
		chk("unmapped err", 32'h0000_0001, {31'h0, er_v});
		chk("unmapped data", ZERO_WORD, rd_v);
		wr(STATUS_OFS, ALL);
		rchk("reserved", STATUS_OFS, ALL, ZERO_WORD);
	endtask : t_regs

	task automatic t_complete;
		wr(ENABLE_OFS, 32'h0004_0000);
		i_tx_path_model.strobe(P_OK, 1);
		rchk("complete", STATUS_OFS, ALL, 32'h0005_0000);
		chk("irq masked", ZERO_WORD, irq);
		wr(ENABLE_OFS, 32'h0005_0000);
		settle();
		chk("irq on", 32'h0000_0001, irq);
		wr(STATUS_OFS, ZERO_WORD);
		rchk("write zero", STATUS_OFS, ALL, 32'h0005_0000);
		wr(STATUS_OFS, 32'h0004_0000);
		rchk("write one", STATUS_OFS, ALL, ZERO_WORD);
		settle();
		chk("irq off", ZERO_WORD, irq);
	endtask : t_complete

	task automatic t_underflow;
		i_tx_path_model.strobe(P_UF, 1);
		#1;
		chk("retransmit", 32'h0000_0001, retx);
		wr(THRESH_OFS, 32'h0000_0003);
		rchk("underflow", STATUS_OFS, ALL, 32'h0002_0000);
		wr(STATUS_OFS, 32'h0002_0000);
	endtask : t_underflow

	task automatic t_carrier;
		wr(COMMAND_OFS, ZERO_WORD);
		i_tx_path_model.set_lvl(1'b1, 1'b0, 1'b0);
		i_tx_path_model.strobe(P_START, 1);
		rchk("no carrier", STATUS_OFS, 32'h0010_0000, 32'h0010_0000);
		wr(STATUS_OFS, 32'h0010_0000);
		i_tx_path_model.set_lvl(1'b0, 1'b0, 1'b0);
		wr(COMMAND_OFS, 32'h0000_0001);
		i_tx_path_model.set_lvl(1'b1, 1'b0, 1'b0);
		i_tx_path_model.strobe(P_START, 1);
		rchk("full duplex", STATUS_OFS, 32'h0010_0000, ZERO_WORD);
		i_tx_path_model.set_lvl(1'b0, 1'b0, 1'b1);
	endtask : t_carrier

	task automatic t_defer;
		wr(COMMAND_OFS, 32'h0000_0002);
		i_tx_path_model.set_lvl(1'b0, 1'b1, 1'b1);
		repeat (3200) @(posedge clk);
		rchk("defer early", STATUS_OFS, 32'h0008_0000, ZERO_WORD);
		repeat (100) @(posedge clk);
		rchk("defer late", STATUS_OFS, 32'h0008_0000, 32'h0008_0000);
		i_tx_path_model.set_lvl(1'b0, 1'b0, 1'b1);
		wr(STATUS_OFS, 32'h0008_0000);
		wr(COMMAND_OFS, 32'h0000_0006);
		i_tx_path_model.set_lvl(1'b0, 1'b1, 1'b1);
		repeat (3400) @(posedge clk);
		rchk("no defer", STATUS_OFS, 32'h0008_0000, ZERO_WORD);
		i_tx_path_model.set_lvl(1'b0, 1'b0, 1'b1);
	endtask : t_defer

	task automatic t_collide;
		wr(COMMAND_OFS, ZERO_WORD);
		i_tx_path_model.set_lvl(1'b1, 1'b0, 1'b1);
		i_tx_path_model.strobe(P_START, 1);
		i_tx_path_model.strobe(P_COL, 15);
		rchk("15 collisions", STATUS_OFS, 32'h0020_0000, ZERO_WORD);
		i_tx_path_model.strobe(P_COL, 1);
		rchk("16 collisions", STATUS_OFS, 32'h0020_0000, 32'h0020_0000);
		i_tx_path_model.strobe(P_OK, 1);
		wr(STATUS_OFS, 32'h0024_0000);
		i_tx_path_model.strobe(P_START, 1);
		i_tx_path_model.strobe(P_BYTE, 63);
		i_tx_path_model.strobe(P_COL, 1);
		rchk("in window", STATUS_OFS, 32'h0040_0000, ZERO_WORD);
		i_tx_path_model.strobe(P_BYTE, 1);
		i_tx_path_model.strobe(P_COL, 1);
		rchk("late", STATUS_OFS, 32'h0040_0000, 32'h0040_0000);
		i_tx_path_model.set_lvl(1'b0, 1'b0, 1'b1);
		wr(STATUS_OFS, ALL);
	endtask : t_collide

	task automatic t_dma;
		wr(ENABLE_OFS, 32'h0181_0000);
		@(posedge clk);
		desc_un <= 1'b1;
		@(posedge clk);
		desc_un <= 1'b0;
		rchk("desc flag", STATUS_OFS, 32'h0181_0000, 32'h0081_0000);
		chk("halted", 32'h0000_0001, halted);
		wr(START_OFS, ZERO_WORD);
		settle();
		chk("restart", ZERO_WORD, halted);
		@(posedge clk);
		bus_err <= 1'b1;
		@(posedge clk);
		bus_err <= 1'b0;
		rchk("bus error", STATUS_OFS, 32'h0181_0000, 32'h0181_0000);
		chk("irq dma", 32'h0000_0001, irq);
		wr(STATUS_OFS, 32'h0180_0000);
		settle();
		chk("irq clear", ZERO_WORD, irq);
	endtask : t_dma

	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_complete();
		t_underflow();
		t_carrier();
		t_defer();
		t_collide();
		t_dma();
		finish_test();
	end
endmodule : tb_mac_tx_interrupt_status

// [tb/tx_path_model.sv]
`timescale 1ns/1ps
module tx_path_model
	import tx_irq_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Transmit path towards the block
	output tx_irq_pkg::tx_path_t path_o
);
	tx_path_t lvl_r = '0;
	tx_path_t pls_r = '0;
	assign path_o = lvl_r | pls_r;
	// Carrier and frame levels move only just after an edge
	task automatic set_lvl(input logic act, input logic dfr, input logic crs);
		@(posedge clk_i);
		lvl_r <= '{frame_active: act, defer_pending: dfr, crs: crs, default: 1'b0};
	endtask : set_lvl
	// A gap cycle between strobes so each one counts once
	task automatic strobe(input tx_path_t p, input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			pls_r <= p;
			@(posedge clk_i);
			pls_r <= '0;
		end
	endtask : strobe
endmodule : tx_path_model
